/* rtl/ckeng_pkg.sv */
// package: register map, field layout and constants of the checksum engine
package ckeng_pkg;
    // register byte offsets on the apb bus
    localparam logic [7:0] CTRL_OFS = 8'h00; // checksum_control_reg
    localparam logic [7:0] BYTEIN_OFS = 8'h04; // byte_input_port
    localparam logic [7:0] DATA_OFS = 8'h08; // result_data_port
    localparam logic [7:0] AUTO_OFS = 8'h0C; // auto_config_reg
    localparam logic [7:0] COUNT_OFS = 8'h10; // sector_count_reg
    // control and auto config register field positions
    localparam int CTRL_SEL_BIT = 4; // poly_width_select
    localparam int CTRL_VAL_BIT = 2; // start_value_select
    localparam int CTRL_INIT_BIT = 3; // result_load_strobe
    localparam int CTRL_PNT_LSB = 0; // result_byte_pointer [1:0]
    localparam int CTRL_BUSY_BIT = 5; // automatic run in progress
    localparam int AUTO_EN_BIT = 7; // auto_mode_enable
    // generator polynomials and start values
    localparam logic [31:0] POLY32 = 32'h04C11DB7;
    localparam logic [31:0] POLY16 = 32'h00001021;
    localparam logic [31:0] START_ZERO = 32'h00000000;
    localparam logic [31:0] START_ONES = 32'hFFFFFFFF;
    // sector geometry and reset values
    localparam logic [15:0] SECTOR_BYTES = 16'h0200;
    localparam int PAGE_SHIFT = 9;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [7:0] AUTO_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
endpackage : ckeng_pkg

/* rtl/ckeng_fifo.sv */
// file holds the small valid/ready fifo for the checksum byte stream
`timescale 1ns/1ns
module ckeng_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH]; // storage words
    logic [AW-1:0] wr_reg; // write pointer
    logic [AW-1:0] rd_reg; // read pointer
    logic [AW:0] cnt_reg; // words held
    wire push = in_valid && in_ready;
    wire pop = out_valid && out_ready;
    // room while not full; the count is one bit wider than the pointers
    assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
    assign out_valid = (cnt_reg != '0);
    assign out_data = mem[rd_reg];
    // storage write, no reset needed
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_reg] <= in_data;
        end
    end
    // pointers and fill count
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_reg <= '0;
            rd_reg <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
            if (pop) rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule : ckeng_fifo

/* rtl/ckeng_top.sv */
// file holds the checksum engine with apb registers and auto memory scan
//
// Functional notes
// (R1) two polynomials: 0x1021 and 0x04C11DB7
// (R2) start value is all zeros or ones
// (R3) select 0 means 32-bit, 1 means 16-bit
// (R4) value select 0 zeros, 1 ones
// (R5) init strobe loads chosen start value
// (R6) each input byte updates the result
// (R7) software writes first page index first
// (R8) software sets auto enable before start
// (R9) sector count sets sectors scanned
// (R10) each sector is 512 bytes
// (R11) any control write starts auto run; the code starts one only with auto enable set and a nonzero sector count
// (R12) processor stalled until auto run done
// (R13) software clears auto enable before readback
// (R14) result is 32 or 16 bits wide
// (R15) byte pointer picks byte, then increments
// (R16) result holds until load, write, data
// (R17) auto bytes fetched upward, same processing
// (R18) 16-bit mode pointer wraps over two bytes
`timescale 1ns/1ns
module ckeng_top
    import ckeng_pkg::*;
#(
    parameter int ADDR_W = 16, // program memory byte address width
    parameter int FIFO_DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic mem_req,
    output logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    output logic cpu_stall
);
    typedef enum logic [1:0] {ST_IDLE, ST_FETCH, ST_WAIT} ckeng_state_e;

    // one byte step of the msb-first crc at either width
    function automatic logic [31:0] ckeng_step(input logic [31:0] crc,
                                               input logic [7:0] din,
                                               input logic narrow);
        logic [31:0] c;
        logic top;
        c = crc;
        for (int i = 7; i >= 0; i--) begin
            if (narrow) begin
                top = c[15] ^ din[i];
                c = {16'h0000, c[14:0], 1'b0} ^ (top ? POLY16 : 32'h0); // R1
            end else begin
                top = c[31] ^ din[i];
                c = {c[30:0], 1'b0} ^ (top ? POLY32 : 32'h0); // R1
            end
        end
        return c;
    endfunction : ckeng_step

    logic [31:0] result_reg; // running result
    logic poly_width_select_reg; // 1 selects 16-bit
    logic start_value_select_reg; // 1 selects all ones
    logic [1:0] result_byte_pointer_reg; // result byte for data port
    logic auto_mode_enable_reg; // automatic mode enable
    logic [6:0] auto_page_reg; // first page index
    logic [7:0] sector_count_reg; // sectors to scan
    ckeng_state_e state_reg; // auto scan state
    logic [ADDR_W-1:0] addr_reg; // next fetch address
    logic [16:0] left_reg; // bytes still to fetch
    logic [16:0] pend_reg; // bytes fetched not yet folded
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic mem_req_reg;
    logic stall_reg;

    // apb decode: answer in the access phase after one wait cycle
    wire acc = psel && penable && !pready_reg;
    wire wr = acc && pwrite;
    wire rd = acc && !pwrite;
    wire hit_ctrl = (paddr == CTRL_OFS);
    wire hit_in = (paddr == BYTEIN_OFS);
    wire hit_dat = (paddr == DATA_OFS);
    wire hit_auto = (paddr == AUTO_OFS);
    wire hit_cnt = (paddr == COUNT_OFS);
    wire hit_any = hit_ctrl || hit_in || hit_dat || hit_auto || hit_cnt;
    wire busy = (state_reg != ST_IDLE);

    // byte stream into the engine: bus bytes or fetched memory bytes
    wire fifo_in_ready;
    wire [7:0] fifo_out_data;
    wire fifo_out_valid;
    wire bus_byte = wr && hit_in && !busy; // R6
    wire src_valid = mem_rvalid || bus_byte; // R17
    wire [7:0] src_data = mem_rvalid ? mem_rdata : pwdata[7:0];

    ckeng_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_data(src_data),
        .in_valid(src_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out_data),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1)
    );

    // control writes and data port accesses
    wire ctrl_wr = wr && hit_ctrl;
    wire init_now = ctrl_wr && pwdata[CTRL_INIT_BIT]; // R5
    wire dat_acc = acc && hit_dat && !busy; // R15
    wire [1:0] pnt_mask = poly_width_select_reg ? 2'b01 : 2'b11; // R18
    wire [1:0] pnt_inc = (result_byte_pointer_reg + 2'b01) & pnt_mask; // R18
    wire start_auto = ctrl_wr && auto_mode_enable_reg && !busy
        && (sector_count_reg != 8'h00); // R11
    wire [31:0] start_val = pwdata[CTRL_VAL_BIT] ? START_ONES
        : START_ZERO; // R2 R4
    wire [4:0] bsh = {result_byte_pointer_reg, 3'b000};
    wire [31:0] byte_mask = 32'h000000FF << bsh;
    wire [31:0] dat_wr_val = (result_reg & ~byte_mask)
        | ({24'h000000, pwdata[7:0]} << bsh);
    wire [7:0] dat_rd_val = 8'(result_reg >> bsh);
    wire [31:0] width_mask = poly_width_select_reg ? 32'h0000FFFF
        : 32'hFFFFFFFF; // R14

    // read data mux
    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h0;
        if (hit_ctrl) begin
            rd_val[CTRL_SEL_BIT] = poly_width_select_reg;
            rd_val[CTRL_VAL_BIT] = start_value_select_reg;
            rd_val[CTRL_PNT_LSB +: 2] = result_byte_pointer_reg;
            rd_val[CTRL_BUSY_BIT] = busy;
        end else if (hit_dat) begin
            rd_val[7:0] = dat_rd_val;
        end else if (hit_auto) begin
            rd_val[AUTO_EN_BIT] = auto_mode_enable_reg;
            rd_val[6:0] = auto_page_reg;
        end else if (hit_cnt) begin
            rd_val[7:0] = sector_count_reg;
        end
    end

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0;
        end else begin
            pready_reg <= acc;
            pslverr_reg <= acc && !hit_any;
            prdata_reg <= rd ? rd_val : 32'h0;
        end
    end

    // configuration registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            poly_width_select_reg <= CTRL_RST[CTRL_SEL_BIT];
            start_value_select_reg <= CTRL_RST[CTRL_VAL_BIT];
            auto_mode_enable_reg <= AUTO_RST[AUTO_EN_BIT];
            auto_page_reg <= AUTO_RST[6:0];
            sector_count_reg <= COUNT_RST;
        end else begin
            if (ctrl_wr && !busy) begin
                poly_width_select_reg <= pwdata[CTRL_SEL_BIT]; // R3
                start_value_select_reg <= pwdata[CTRL_VAL_BIT]; // R4
            end
            if (wr && hit_auto && !busy) begin
                auto_mode_enable_reg <= pwdata[AUTO_EN_BIT]; // R8 R13
                auto_page_reg <= pwdata[6:0]; // R7
            end
            if (wr && hit_cnt && !busy) begin
                sector_count_reg <= pwdata[7:0]; // R9
            end
        end
    end

    // byte pointer: set by control write, steps after each data access made while no auto run is busy
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_byte_pointer_reg <= CTRL_RST[1:0];
        end else if (ctrl_wr && !busy) begin
            result_byte_pointer_reg <= pwdata[1:0] & (pwdata[CTRL_SEL_BIT]
                ? 2'b01 : 2'b11); // R18
        end else if (dat_acc) begin
            result_byte_pointer_reg <= pnt_inc; // R15
        end
    end

    // result: load, data port write or byte fold, else hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            result_reg <= START_ZERO;
        end else if (init_now && !busy) begin
            result_reg <= start_val & (pwdata[CTRL_SEL_BIT] ? 32'h0000FFFF
                : 32'hFFFFFFFF); // R5 R14
        end else if (dat_acc && pwrite) begin
            result_reg <= dat_wr_val & width_mask; // R15 R16
        end else if (fifo_out_valid) begin
            result_reg <= ckeng_step(result_reg, fifo_out_data,
                poly_width_select_reg) & width_mask; // R6 R14
        end
    end

    // auto scan: fetch sectors upward, stall cpu until all folded
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= ST_IDLE;
            addr_reg <= '0;
            left_reg <= '0;
            pend_reg <= '0;
            mem_req_reg <= 1'b0;
            stall_reg <= 1'b0;
        end else begin
            pend_reg <= pend_reg + 17'(mem_req_reg) - 17'(fifo_out_valid
                && busy);
            case (state_reg)
                ST_IDLE: begin
                    mem_req_reg <= 1'b0;
                    if (start_auto) begin
                        state_reg <= ST_FETCH;
                        stall_reg <= 1'b1; // R12
                        addr_reg <= ADDR_W'({auto_page_reg,
                            {PAGE_SHIFT{1'b0}}}); // R17
                        left_reg <= 17'(sector_count_reg) *
                            17'(SECTOR_BYTES); // R9 R10
                        pend_reg <= '0;
                    end
                end
                ST_FETCH: begin
                    // one request per byte while fifo has room
                    if (left_reg != '0 && fifo_in_ready && !mem_req_reg
                        && pend_reg < 17'(FIFO_DEPTH - 1)) begin
                        mem_req_reg <= 1'b1;
                        left_reg <= left_reg - 17'd1;
                    end else begin
                        mem_req_reg <= 1'b0;
                    end
                    if (mem_req_reg) addr_reg <= addr_reg + 1'b1; // R17
                    if (left_reg == '0 && !mem_req_reg) state_reg <= ST_WAIT;
                end
                default: begin
                    mem_req_reg <= 1'b0;
                    if (pend_reg == '0 && !fifo_out_valid) begin
                        state_reg <= ST_IDLE;
                        stall_reg <= 1'b0; // R12
                    end
                end
            endcase
        end
    end

    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign mem_req = mem_req_reg;
    assign mem_addr = addr_reg;
    assign cpu_stall = stall_reg;
endmodule : ckeng_top

/* test/ckeng_props.sv */
// checker: bus timing and automatic scan properties of the engine
`timescale 1ns/1ns
module ckeng_props
    import ckeng_pkg::*;
#(
    parameter int ADDR_W = 16
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic mem_req,
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic [7:0] mem_rdata,
    input wire logic mem_rvalid,
    input wire logic cpu_stall
);
    logic auto_reg; // shadow of the auto enable bit
    logic [6:0] page_reg; // shadow of the first page
    logic [7:0] cnt_reg; // shadow of the sector count
    logic [17:0] req_cnt; // fetches since the last start
    logic [ADDR_W-1:0] last_addr; // address of the previous fetch
    wire taken = psel && penable && !pready;
    wire wr_ok = taken && pwrite && !cpu_stall;
    wire unmapped = !(paddr inside {CTRL_OFS, BYTEIN_OFS, DATA_OFS,
        AUTO_OFS, COUNT_OFS});
    wire start = wr_ok && paddr == CTRL_OFS && auto_reg && cnt_reg != 8'h00;
    // track the auto setup and tally the fetches of a run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_reg <= 1'b0;
            page_reg <= 7'h00;
            cnt_reg <= 8'h00;
            req_cnt <= 18'h00000;
            last_addr <= '0;
        end else begin
            if (wr_ok && paddr == AUTO_OFS) begin
                auto_reg <= pwdata[AUTO_EN_BIT];
                page_reg <= pwdata[6:0];
            end
            if (wr_ok && paddr == COUNT_OFS) cnt_reg <= pwdata[7:0];
            if (start) req_cnt <= 18'h00000;
            else if (mem_req) req_cnt <= req_cnt + 18'h00001;
            if (mem_req) last_addr <= mem_addr;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY_AFTER_TAKE: assert property (taken |=> pready &&
        pslverr == $past(unmapped)) else $error("bad answer to access");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("ready held too long");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("error without ready");
    AST_IDLE_RDATA: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside answer");
    AST_STALL_START: assert property (start |=> ##[0:1] cpu_stall)
        else $error("auto run did not stall");
    AST_REQ_IN_STALL: assert property (mem_req |-> cpu_stall)
        else $error("fetch outside auto run");
    AST_FIRST_FETCH: assert property (start |-> ##[1:4] (mem_req &&
        mem_addr == ADDR_W'({page_reg, 9'h000}))) else $error("first fetch");
    AST_ADDR_STEP: assert property (mem_req && req_cnt != 0 |->
        mem_addr == last_addr + 1'b1) else $error("fetch not sequential");
    AST_SECTOR_TOTAL: assert property ($fell(cpu_stall) |->
        req_cnt == {1'b0, cnt_reg, 9'h000}) else $error("fetch total");
endmodule : ckeng_props
bind ckeng_top ckeng_props #(.ADDR_W(ADDR_W)) u_props (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .mem_rvalid(mem_rvalid), .cpu_stall(cpu_stall));

/* test/ckeng_mem_model.sv */
// program memory model answering each fetch one cycle later
`timescale 1ns/1ns
module ckeng_mem_model (
    input wire logic clk,
    input wire logic req,
    input wire logic [15:0] addr,
    output logic [7:0] rdata,
    output logic rvalid
);
    // zero outputs at start; rvalid stays low until the first fetch
    initial begin
        rvalid = 1'b0;
        rdata = 8'h00;
    end
    // data tied to address; lines toggle when nothing is answered
    always @(posedge clk) begin
        rvalid <= req;
        rdata <= req ? (addr[7:0] ^ addr[15:8] ^ 8'hA5) : ~rdata;
    end
endmodule : ckeng_mem_model

/* test/tb.sv */
// testbench: registers, byte checksums and an automatic scan
`timescale 1ns/1ns
module tb
    import ckeng_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, mem_req, mem_rvalid, cpu_stall;
    logic [15:0] mem_addr;
    logic [7:0] mem_rdata;
    logic [9:0] note_q[$]; // bit9 data checked, bit8 error expected
    logic [9:0] note;
    logic [31:0] lfsr = 32'h000102A7; // random byte source
    int fails = 0;
    int n_compared = 0;
    int cyc = 0;
    always #10 pclk = ~pclk;
    ckeng_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_req(mem_req), .mem_addr(mem_addr), .mem_rdata(mem_rdata),
        .mem_rvalid(mem_rvalid), .cpu_stall(cpu_stall));
    ckeng_mem_model u_mem (.clk(pclk), .req(mem_req), .addr(mem_addr),
        .rdata(mem_rdata), .rvalid(mem_rvalid));
    task automatic check(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic wrap_up;
        if (fails == 0 && n_compared > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : wrap_up
    // one apb transfer; the expectation goes on the queue first
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d, input logic [9:0] nt);
        @(posedge pclk);
        note_q.push_back(nt);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h000000, d}, 10'h000);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, {2'b10, e});
    endtask : rd
    function automatic logic [31:0] nxt(input logic [31:0] l);
        return {l[30:0], l[31] ^ l[21] ^ l[1] ^ l[0]};
    endfunction : nxt
    // msb-first checksum step over one byte
    function automatic logic [31:0] crc_b(input logic [31:0] c,
        input logic [7:0] b, input logic w16);
        logic [31:0] top;
        top = w16 ? 32'h00008000 : 32'h80000000;
        c = c ^ (w16 ? {16'h0000, b, 8'h00} : {b, 24'h000000});
        for (int i = 0; i < 8; i++) begin
            c = (c & top) != 0 ? ((c << 1) ^ (w16 ? POLY16 : POLY32)) : c << 1;
        end
        return w16 ? (c & 32'h0000FFFF) : c;
    endfunction : crc_b
    // compare every answer against the oldest note
    always @(posedge pclk) begin
        if (presetn === 1'b1 && pready === 1'b1) begin
            note = note_q.pop_front();
            check("pslverr", 8'(pslverr), 8'(note[8]));
            if (note[9]) check("prdata", prdata[7:0], note[7:0]);
        end
    end
    // cut a hang short
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            wrap_up();
        end
    end
    initial begin
        logic [31:0] crc;
        logic sel;
        int n;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(CTRL_OFS, 8'h00);
        rd(AUTO_OFS, 8'h00);
        rd(COUNT_OFS, 8'h00);
        apb(1'b0, 8'h14, 32'h0, 10'h100);
        // every width and start value, random bytes, pointer wrap
        for (int m = 0; m < 4; m++) begin
            sel = m[1];
            crc = m[0] ? START_ONES : START_ZERO;
            wr(CTRL_OFS, {3'b000, sel, 1'b1, m[0], 2'b00});
            repeat (5) begin
                lfsr = nxt(lfsr);
                crc = crc_b(crc, lfsr[7:0], sel);
                wr(BYTEIN_OFS, lfsr[7:0]);
            end
            for (int k = 0; k < 4 - int'(sel); k++) begin
                rd(DATA_OFS, crc[8 * (sel ? k % 2 : k) +: 8]);
            end
        end
        wr(CTRL_OFS, 8'h02);
        wr(DATA_OFS, 8'h3C);
        wr(CTRL_OFS, 8'h02);
        rd(DATA_OFS, 8'h3C);
        // automatic scan of page one, one sector
        wr(CTRL_OFS, 8'h0C);
        wr(AUTO_OFS, 8'h81);
        wr(COUNT_OFS, 8'h01);
        wr(CTRL_OFS, 8'h0C);
        crc = START_ONES;
        for (int a = 512; a < 1024; a++) begin
            crc = crc_b(crc, 8'(a) ^ 8'(a >> 8) ^ 8'hA5, 1'b0);
        end
        repeat (2) @(posedge pclk);
        check("stall", 8'(cpu_stall), 8'h01);
        wr(BYTEIN_OFS, 8'h55);
        n = 0;
        while (cpu_stall !== 1'b0 && n < 4000) begin
            @(posedge pclk);
            n++;
        end
        check("stall end", 8'(cpu_stall), 8'h00);
        wr(AUTO_OFS, 8'h00);
        for (int k = 0; k < 4; k++) rd(DATA_OFS, crc[8 * k +: 8]);
        wrap_up();
    end
endmodule : tb
